// file: src/lcs_defs.svh
// Purpose: offsets, field positions, reset values and counts of the link
//          control and status register bank
// Assumes: register index is the value on address bits A1-A6
// Notes:   only the low data byte carries register data
`ifndef LCS_DEFS_SVH
`define LCS_DEFS_SVH

`define LCS_IDX_CMD        6'h00
`define LCS_IDX_STAT0      6'h01
`define LCS_IDX_STAT13     6'h0e
`define LCS_IDX_IRQ        6'h0f
`define LCS_IDX_PARAM0     6'h10
`define LCS_IDX_PARAM1     6'h11
`define LCS_IDX_PARAM15    6'h1f
`define LCS_IDX_CNT0       6'h20
`define LCS_IDX_CNT17      6'h31
`define LCS_IDX_PARAM16    6'h32

`define LCS_CMD_RESET      8'h82
`define LCS_CMD_SEND       0
`define LCS_CMD_FDISC      1
`define LCS_CMD_RXRDY      2
`define LCS_CMD_ACTIVE     3
`define LCS_CMD_PWINIT     4
`define LCS_CMD_DISCSEL    7

`define LCS_RST_SEQ_CYC    4'h8
`define LCS_IRQ_DEPTH      3'h4
`define LCS_ST_INFO_MIN    5'h06
`define LCS_ST_SETUP       5'h04
`define LCS_ST_BUSY_A      5'h0d
`define LCS_ST_BUSY_B      5'h0f
`define LCS_ST_BUSY_C      5'h10
`define LCS_ST_BUSY_D      5'h11
`define LCS_ST_BUSY_E      5'h1a
`define LCS_ST_BUSY_F      5'h1b

`endif

// file: src/lcs_pkg.sv
// Purpose: types of the link control and status register bank
// Assumes: nothing beyond the defs header
// Notes:   no constants here, only enumerations
package lcs_pkg;

	typedef enum logic [1:0] {
		LCS_RST_SEQ,
		LCS_SETUP,
		LCS_OPER
	} lcs_phase_type;

	typedef enum logic [2:0] {
		LCS_DA_HOLD_IDLE,
		LCS_DA_DM_FLAG_FILL,
		LCS_DA_REMOTE_INIT,
		LCS_DA_ACTIVE_SETUP,
		LCS_DA_WAIT_ID,
		LCS_DA_INIT_ID,
		LCS_DA_ILLEGAL
	} lcs_disc_action_type;

endpackage

// file: src/lcs_regs.sv
// Purpose: host register bank, reset sequencing and board isolation
// Assumes: protocol engine supplies state, sequence values and events on
//          i_sys_clk; host pins are asynchronous and synchronised here
// Notes:   parameter and counter contents live outside; this block gates
//          their writes and returns their read data
`timescale 1ns/1ps
`include "lcs_defs.svh"

module lcs_regs (
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_rst_b,
	input  wire logic                       i_master_reset_n,
	input  wire logic                       i_cs_n,
	input  wire logic                       i_rd_n,
	input  wire logic                       i_wr_n,
	input  wire logic [5:0]                 i_addr,
	input  wire logic [7:0]                 i_data,
	output logic      [7:0]                 o_data,
	output logic                            o_data_oe,
	output logic                            o_data_hi_oe,
	output logic                            o_iso_group_oe,
	output logic                            o_other_oe,
	output logic                            o_interrupt_request_n,
	input  wire logic [4:0]                 i_proto_state,
	input  wire logic [6:0]                 i_send_seq,
	input  wire logic [6:0]                 i_recv_seq,
	input  wire logic                       i_internal_send_request,
	input  wire logic [6:0]                 i_next_ack_expected,
	input  wire logic [6:0]                 i_prev_next_ack,
	input  wire logic                       i_ack_processing_pending,
	input  wire logic [15:0]                i_rx_control,
	input  wire logic [3:0]                 i_chain_segment,
	input  wire logic [4:0]                 i_protocol_input,
	input  wire logic                       i_last_poll_final,
	input  wire logic [39:0]                i_reject_bytes,
	input  wire logic                       i_modulo_128,
	input  wire logic                       i_id_exchange_enable,
	input  wire logic [7:0]                 i_ext_rdata,
	input  wire logic                       i_irq_valid,
	input  wire logic [5:0]                 i_irq_code,
	input  wire logic                       i_evt_link_down,
	input  wire logic                       i_evt_tx_not_ready,
	input  wire logic                       i_evt_rx_fault,
	input  wire logic                       i_evt_link_reset_rx,
	input  wire logic                       i_evt_iframe_lost,
	output logic [7:0]                      o_link_command,
	output logic                            o_tx_fill_ones,
	output logic                            o_rx_discard,
	output logic                            o_params_clear,
	output logic                            o_send_disc_frame,
	output logic                            o_enter_station_busy,
	output logic [2:0]                      o_pw_verdict,
	output lcs_pkg::lcs_disc_action_type    o_disc_action,
	output logic                            o_param_wr,
	output logic                            o_counter_wr,
	output logic [5:0]                      o_ext_index,
	output logic [7:0]                      o_ext_wdata
);

	// host pins pass two flip-flops before use
	logic [17:0] sync1_ff;
	logic [17:0] sync2_ff;
	logic        rd_n_d_ff;
	logic        wr_n_d_ff;

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync1_ff  <= {4'hf, 14'h0000};
			sync2_ff  <= {4'hf, 14'h0000};
			rd_n_d_ff <= 1'b1;
			wr_n_d_ff <= 1'b1;
		end else begin
			sync1_ff  <= {i_master_reset_n, i_cs_n, i_rd_n, i_wr_n,
				i_addr, i_data};
			sync2_ff  <= sync1_ff;
			rd_n_d_ff <= sync2_ff[15];
			wr_n_d_ff <= sync2_ff[14];
		end
	end

	logic       mr_act;
	logic       cs_s;
	logic [5:0] addr_s;
	logic [7:0] data_s;
	logic       rd_edge;
	logic       wr_edge;

	assign mr_act  = !sync2_ff[17];
	assign cs_s    = !sync2_ff[16];
	assign addr_s  = sync2_ff[13:8];
	assign data_s  = sync2_ff[7:0];
	assign rd_edge = cs_s && !sync2_ff[15] && rd_n_d_ff;
	assign wr_edge = cs_s && !sync2_ff[14] && wr_n_d_ff;

	function automatic logic in_info(input logic [4:0] st);
		in_info = (st >= `LCS_ST_INFO_MIN);
	endfunction

	function automatic logic in_busy(input logic [4:0] st);
		in_busy = (st == `LCS_ST_BUSY_A) || (st == `LCS_ST_BUSY_B) ||
			(st == `LCS_ST_BUSY_C) || (st == `LCS_ST_BUSY_D) ||
			(st == `LCS_ST_BUSY_E) || (st == `LCS_ST_BUSY_F);
	endfunction

	logic info_now;
	assign info_now = in_info(i_proto_state);

	// interrupt reason queue storage
	logic [5:0] q_mem [0:3];
	logic [1:0] q_wp_ff;
	logic [1:0] q_rp_ff;
	logic [2:0] q_cnt_ff;
	logic       q_push;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_q
			always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					q_mem[gi] <= 6'h00;
				end else if (q_push && (q_wp_ff == 2'(gi))) begin
					q_mem[gi] <= i_irq_code;
				end
			end
		end
	endgenerate

	lcs_pkg::lcs_phase_type phase_ff;
	lcs_pkg::lcs_phase_type nxt_phase;
	logic [3:0] seq_cnt_ff;
	logic [3:0] nxt_seq_cnt;
	logic [7:0] cmd_ff;
	logic [7:0] nxt_cmd;
	logic [1:0] nxt_q_wp;
	logic [1:0] nxt_q_rp;
	logic [2:0] nxt_q_cnt;
	logic       lost_ff;
	logic       nxt_lost;
	logic       ovf_ff;
	logic       nxt_ovf;
	logic       host_done_n_ff;
	logic       nxt_host_done_n;
	logic       iflost_ff;
	logic       nxt_iflost;
	logic       info_d_ff;
	logic       busy_d_ff;
	logic       iso_ff;
	logic       nxt_iso;
	logic       mr_d_ff;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic       param_wr_ff;
	logic       nxt_param_wr;
	logic       cnt_wr_ff;
	logic       nxt_cnt_wr;
	logic [5:0] ext_idx_ff;
	logic [7:0] ext_wd_ff;
	logic       disc_pulse_ff;
	logic       nxt_disc_pulse;
	logic       busy_pulse_ff;
	logic       nxt_busy_pulse;
	logic       q_pop;
	logic       rd_irq;
	logic       rd_st0;

	assign rd_irq = rd_edge && (addr_s == `LCS_IDX_IRQ);
	assign rd_st0 = rd_edge && (addr_s == `LCS_IDX_STAT0);
	assign q_pop  = rd_irq && (q_cnt_ff != 3'h0);
	// a pop in the same cycle makes room for the push
	assign q_push = i_irq_valid && !mr_act &&
		((q_cnt_ff != `LCS_IRQ_DEPTH) || q_pop);

	always_comb begin
		nxt_phase      = phase_ff;
		nxt_seq_cnt    = seq_cnt_ff;
		nxt_cmd        = cmd_ff;
		nxt_q_wp       = q_wp_ff;
		nxt_q_rp       = q_rp_ff;
		nxt_q_cnt      = q_cnt_ff;
		nxt_lost       = lost_ff;
		nxt_ovf        = ovf_ff;
		nxt_host_done_n     = host_done_n_ff;
		nxt_iflost     = iflost_ff;
		nxt_iso        = iso_ff;
		nxt_rdata      = rdata_ff;
		nxt_param_wr   = 1'b0;
		nxt_cnt_wr     = 1'b0;
		nxt_disc_pulse = 1'b0;
		nxt_busy_pulse = 1'b0;
		case (phase_ff)
			lcs_pkg::LCS_RST_SEQ: begin
				nxt_seq_cnt = seq_cnt_ff + 4'h1;
				if (seq_cnt_ff == `LCS_RST_SEQ_CYC - 4'h1) begin
					nxt_phase = lcs_pkg::LCS_SETUP;
				end
			end
			lcs_pkg::LCS_SETUP: begin
				if (!cmd_ff[`LCS_CMD_FDISC]) begin
					nxt_phase = lcs_pkg::LCS_OPER;
				end
			end
			lcs_pkg::LCS_OPER: begin
				nxt_phase = lcs_pkg::LCS_OPER;
			end
			default: begin
				nxt_phase = lcs_pkg::LCS_RST_SEQ;
			end
		endcase
		if (wr_edge) begin
			case (addr_s)
				`LCS_IDX_CMD: begin
					nxt_cmd = data_s;
				end
				default: begin
					nxt_cmd = cmd_ff;
				end
			endcase
			if ((addr_s >= `LCS_IDX_PARAM0 && addr_s <= `LCS_IDX_PARAM15) ||
				addr_s == `LCS_IDX_PARAM16) begin
				nxt_param_wr = cmd_ff[`LCS_CMD_FDISC] &&
					(phase_ff != lcs_pkg::LCS_RST_SEQ) &&
					((addr_s != `LCS_IDX_PARAM0) ||
					(phase_ff == lcs_pkg::LCS_SETUP));
			end
			nxt_cnt_wr = (addr_s >= `LCS_IDX_CNT0) &&
				(addr_s <= `LCS_IDX_CNT17);
		end
		// hardware clears win over a host write in the same cycle
		if (i_evt_link_down || i_evt_tx_not_ready) begin
			nxt_cmd[`LCS_CMD_SEND] = 1'b0;
		end
		if (i_evt_rx_fault) begin
			nxt_cmd[`LCS_CMD_RXRDY] = 1'b0;
		end
		if (info_now && nxt_cmd[`LCS_CMD_FDISC] &&
			!cmd_ff[`LCS_CMD_FDISC]) begin
			nxt_disc_pulse = 1'b1;
		end
		if (info_now && !nxt_cmd[`LCS_CMD_RXRDY] &&
			cmd_ff[`LCS_CMD_RXRDY]) begin
			nxt_busy_pulse = 1'b1;
		end
		if (q_pop) begin
			nxt_q_rp = q_rp_ff + 2'h1;
		end
		if (q_push) begin
			nxt_q_wp = q_wp_ff + 2'h1;
		end
		nxt_q_cnt = q_cnt_ff + {2'h0, q_push} - {2'h0, q_pop};
		if (rd_irq) begin
			nxt_lost = 1'b0;
		end
		if (rd_st0) begin
			nxt_ovf = 1'b0;
		end
		if (i_irq_valid && !mr_act && !q_push) begin
			nxt_lost = 1'b1;
			nxt_ovf  = 1'b1;
		end
		if (wr_edge && (addr_s == `LCS_IDX_STAT0 ||
			addr_s == `LCS_IDX_PARAM1)) begin
			nxt_host_done_n = 1'b0;
		end
		if ((i_evt_link_reset_rx && info_now) || (info_d_ff && !info_now)) begin
			nxt_host_done_n = 1'b1;
		end
		if (busy_d_ff && !in_busy(i_proto_state)) begin
			nxt_iflost = 1'b0;
		end
		if (i_evt_iframe_lost) begin
			nxt_iflost = 1'b1;
		end
		if (mr_act && !mr_d_ff) begin
			nxt_iso = cs_s;
		end else if (!mr_act) begin
			nxt_iso = 1'b0;
		end
		if (rd_edge) begin
			case (addr_s)
				`LCS_IDX_CMD:  nxt_rdata = cmd_ff;
				6'h01: nxt_rdata = {host_done_n_ff,
					(i_proto_state >= `LCS_ST_SETUP), ovf_ff, i_proto_state};
				6'h02: nxt_rdata = {info_now, i_send_seq};
				6'h03: nxt_rdata = {!i_internal_send_request, i_recv_seq};
				6'h04: nxt_rdata = {i_ack_processing_pending,
					i_next_ack_expected};
				6'h05: nxt_rdata = {i_ack_processing_pending, i_prev_next_ack};
				6'h06: nxt_rdata = i_rx_control[7:0];
				6'h07: nxt_rdata = i_modulo_128 ? i_rx_control[15:8] : 8'h00;
				6'h08: nxt_rdata = {4'h0, i_chain_segment};
				6'h09: nxt_rdata = {1'b0, iflost_ff,
					i_last_poll_final, i_protocol_input};
				6'h0a: nxt_rdata = i_reject_bytes[7:0];
				6'h0b: nxt_rdata = i_reject_bytes[15:8];
				6'h0c: nxt_rdata = i_reject_bytes[23:16];
				6'h0d: nxt_rdata = i_modulo_128 ? i_reject_bytes[31:24] : 8'h00;
				`LCS_IDX_STAT13: nxt_rdata = i_modulo_128 ?
					i_reject_bytes[39:32] : 8'h00;
				`LCS_IDX_IRQ: nxt_rdata = {lost_ff, 1'b0,
					(q_cnt_ff != 3'h0) ? q_mem[q_rp_ff] : 6'h00};
				default: nxt_rdata = (addr_s <= `LCS_IDX_PARAM16) ?
					i_ext_rdata : 8'h00;
			endcase
		end
		if (mr_act) begin
			nxt_phase    = lcs_pkg::LCS_RST_SEQ;
			nxt_seq_cnt  = 4'h0;
			nxt_cmd      = `LCS_CMD_RESET;
			nxt_q_wp     = 2'h0;
			nxt_q_rp     = 2'h0;
			nxt_q_cnt    = 3'h0;
			nxt_lost     = 1'b0;
			nxt_param_wr = 1'b0;
			nxt_cnt_wr   = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			phase_ff      <= lcs_pkg::LCS_RST_SEQ;
			seq_cnt_ff    <= 4'h0;
			cmd_ff        <= `LCS_CMD_RESET;
			q_wp_ff       <= 2'h0;
			q_rp_ff       <= 2'h0;
			q_cnt_ff      <= 3'h0;
			lost_ff       <= 1'b0;
			ovf_ff        <= 1'b0;
			host_done_n_ff     <= 1'b0;
			iflost_ff     <= 1'b0;
			info_d_ff     <= 1'b0;
			busy_d_ff     <= 1'b0;
			iso_ff        <= 1'b0;
			mr_d_ff       <= 1'b0;
			rdata_ff      <= 8'h00;
			param_wr_ff   <= 1'b0;
			cnt_wr_ff     <= 1'b0;
			ext_idx_ff    <= 6'h00;
			ext_wd_ff     <= 8'h00;
			disc_pulse_ff <= 1'b0;
			busy_pulse_ff <= 1'b0;
		end else begin
			phase_ff      <= nxt_phase;
			seq_cnt_ff    <= nxt_seq_cnt;
			cmd_ff        <= nxt_cmd;
			q_wp_ff       <= nxt_q_wp;
			q_rp_ff       <= nxt_q_rp;
			q_cnt_ff      <= nxt_q_cnt;
			lost_ff       <= nxt_lost;
			ovf_ff        <= nxt_ovf;
			host_done_n_ff     <= nxt_host_done_n;
			iflost_ff     <= nxt_iflost;
			info_d_ff     <= info_now;
			busy_d_ff     <= in_busy(i_proto_state);
			iso_ff        <= nxt_iso;
			mr_d_ff       <= mr_act;
			rdata_ff      <= nxt_rdata;
			param_wr_ff   <= nxt_param_wr;
			cnt_wr_ff     <= nxt_cnt_wr;
			ext_idx_ff    <= wr_edge ? addr_s : ext_idx_ff;
			ext_wd_ff     <= wr_edge ? data_s : ext_wd_ff;
			disc_pulse_ff <= nxt_disc_pulse;
			busy_pulse_ff <= nxt_busy_pulse;
		end
	end

	always_comb begin
		o_disc_action = lcs_pkg::LCS_DA_HOLD_IDLE;
		if (cmd_ff[`LCS_CMD_FDISC]) begin
			o_disc_action = lcs_pkg::LCS_DA_HOLD_IDLE;
		end else if (i_id_exchange_enable) begin
			if (cmd_ff[`LCS_CMD_DISCSEL]) begin
				o_disc_action = lcs_pkg::LCS_DA_ILLEGAL;
			end else if (cmd_ff[`LCS_CMD_PWINIT]) begin
				o_disc_action = lcs_pkg::LCS_DA_INIT_ID;
			end else begin
				o_disc_action = lcs_pkg::LCS_DA_WAIT_ID;
			end
		end else if (cmd_ff[`LCS_CMD_ACTIVE]) begin
			o_disc_action = lcs_pkg::LCS_DA_ACTIVE_SETUP;
		end else if (cmd_ff[`LCS_CMD_DISCSEL]) begin
			o_disc_action = lcs_pkg::LCS_DA_REMOTE_INIT;
		end else begin
			o_disc_action = lcs_pkg::LCS_DA_DM_FLAG_FILL;
		end
	end

	assign o_link_command        = cmd_ff;
	assign o_pw_verdict          = cmd_ff[6:4];
	assign o_data                = rdata_ff;
	assign o_data_oe             = cs_s && !sync2_ff[15] && !mr_act;
	assign o_data_hi_oe          = 1'b0;
	assign o_iso_group_oe        = !(mr_act && iso_ff);
	assign o_other_oe            = !mr_act;
	assign o_interrupt_request_n = (q_cnt_ff == 3'h0);
	assign o_tx_fill_ones        = (phase_ff != lcs_pkg::LCS_OPER) ||
		cmd_ff[`LCS_CMD_FDISC];
	assign o_rx_discard          = (phase_ff != lcs_pkg::LCS_OPER);
	assign o_params_clear        = mr_act;
	assign o_send_disc_frame     = disc_pulse_ff;
	assign o_enter_station_busy  = busy_pulse_ff;
	assign o_param_wr            = param_wr_ff;
	assign o_counter_wr          = cnt_wr_ff;
	assign o_ext_index           = ext_idx_ff;
	assign o_ext_wdata           = ext_wd_ff;

	property p_rst_seq;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		$rose(phase_ff == lcs_pkg::LCS_SETUP) |->
			$past(phase_ff == lcs_pkg::LCS_RST_SEQ, 8);
	endproperty
	a_rst_seq: assert property (p_rst_seq) else $error("reset seq length");

	property p_setup_fill;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(phase_ff == lcs_pkg::LCS_SETUP) && !cmd_ff[`LCS_CMD_FDISC] &&
			!mr_act |=> (phase_ff == lcs_pkg::LCS_OPER) && !o_rx_discard;
	endproperty
	a_setup_fill: assert property (p_setup_fill) else $error("setup fill");

	property p_param_gate;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		o_param_wr |-> $past(cmd_ff[`LCS_CMD_FDISC]);
	endproperty
	a_param_gate: assert property (p_param_gate) else $error("param gate");

	property p_iso;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(mr_act && !mr_d_ff) ##1 mr_act |->
			!o_other_oe && (o_iso_group_oe == !$past(cs_s));
	endproperty
	a_iso: assert property (p_iso) else $error("isolation enables");

	property p_irq_empty;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		rd_irq && (q_cnt_ff == 3'h0) && !lost_ff |=> o_data == 8'h00;
	endproperty
	a_irq_empty: assert property (p_irq_empty) else $error("empty irq read");

	property p_lost_clr;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		rd_irq && !i_irq_valid |=> !lost_ff;
	endproperty
	a_lost_clr: assert property (p_lost_clr) else $error("lost not cleared");

	property p_cmd_reset;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		mr_act ##1 mr_act |-> o_link_command == `LCS_CMD_RESET;
	endproperty
	a_cmd_reset: assert property (p_cmd_reset) else $error("cmd reset value");

	property p_send_clr;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_evt_link_down || i_evt_tx_not_ready) && !mr_act |=> !cmd_ff[0];
	endproperty
	a_send_clr: assert property (p_send_clr) else $error("send not cleared");

	property p_rxrdy_clr;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_evt_rx_fault && !mr_act |=> !cmd_ff[`LCS_CMD_RXRDY];
	endproperty
	a_rxrdy_clr: assert property (p_rxrdy_clr) else $error("rx ready kept");

	property p_host_done_n;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		info_d_ff && !info_now |=> host_done_n_ff;
	endproperty
	a_host_done_n: assert property (p_host_done_n) else $error("host done not set");

	property p_ovf;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_irq_valid && !mr_act && (q_cnt_ff == 3'h4) && !rd_irq |=> ovf_ff;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not flagged");

	c_full: cover property (@(posedge i_sys_clk) q_cnt_ff == 3'h4);
	c_oper: cover property (@(posedge i_sys_clk)
		phase_ff == lcs_pkg::LCS_OPER);
	c_disc: cover property (@(posedge i_sys_clk) o_send_disc_frame);
	c_iso:  cover property (@(posedge i_sys_clk) !o_iso_group_oe);

endmodule

// file: verif/lcs_host_model.sv
// Purpose: host cpu model driving the register strobes
// Assumes: pins change only at falling clock edges
// Notes:   each strobe level is held long enough to clear the 2-ff sync
`timescale 1ns/1ps
module lcs_host_model (
	input  wire logic       i_sys_clk,
	input  wire logic [7:0] i_rdata,
	output logic            o_cs_n,
	output logic            o_rd_n,
	output logic            o_wr_n,
	output logic [5:0]      o_addr,
	output logic [7:0]      o_wdata
);
	initial begin
		o_cs_n  = 1'b1;
		o_rd_n  = 1'b1;
		o_wr_n  = 1'b1;
		o_addr  = 6'h00;
		o_wdata = 8'h00;
	end
	task automatic access(input logic is_wr, input logic [5:0] idx,
		input logic [7:0] val, output logic [7:0] rdata);
		@(negedge i_sys_clk);
		o_addr  = idx;
		o_wdata = val;
		o_cs_n  = 1'b0;
		o_wr_n  = ~is_wr;
		o_rd_n  = is_wr;
		repeat (4) @(negedge i_sys_clk);
		rdata   = i_rdata;
		o_cs_n  = 1'b1;
		o_wr_n  = 1'b1;
		o_rd_n  = 1'b1;
		// released bus must not keep the old value
		o_wdata = ~val;
		repeat (3) @(negedge i_sys_clk);
	endtask
	task automatic hold_cs(input logic lvl);
		@(negedge i_sys_clk);
		o_cs_n = lvl;
	endtask
endmodule

// file: verif/lcs_regs_bench.sv
// Purpose: self-checking bench of the register bank
// Assumes: host model owns the bus pins
// Notes:   engine inputs are plain bench variables
`timescale 1ns/1ps
`include "lcs_defs.svh"
module lcs_regs_bench;
	logic       clk;
	logic       rst_b;
	logic       mr_n;
	logic [4:0] state;
	logic [6:0] seq;
	logic       flag;
	logic       irq_v;
	logic [5:0] irq_c;
	logic [4:0] evt;
	logic       cs_n;
	logic       rd_n;
	logic       wr_n;
	logic [5:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [7:0] v;
	logic       irq_n;
	logic       iso_oe;
	logic       oth_oe;
	logic       hi_oe;
	logic       fill1;
	logic       disc;
	logic       pwr;
	logic       cwr;
	int         mismatches;
	int         num_checks;
	int         n_pw;
	int         n_cw;
	int         n_oe;
	int         n_sd;
	int         n_sb;
	logic       doe;
	logic       pclr;
	logic       sdf;
	logic       sbf;
	logic       xid;
	logic       m128;
	logic [2:0] da;
	logic [2:0] pwv;
	logic [7:0] lcmd;
	logic [5:0] eidx;
	logic [7:0] ewd;

	initial clk = 1'b0;
	always #50 clk = ~clk;

	lcs_host_model host_u (.i_sys_clk(clk), .i_rdata(rdata), .o_cs_n(cs_n),
		.o_rd_n(rd_n), .o_wr_n(wr_n), .o_addr(addr), .o_wdata(wdata));

	lcs_regs dut_u (
		.i_sys_clk(clk), .i_rst_b(rst_b), .i_master_reset_n(mr_n),
		.i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr(addr),
		.i_data(wdata), .o_data(rdata), .o_data_oe(doe),
		.o_data_hi_oe(hi_oe),
		.o_iso_group_oe(iso_oe), .o_other_oe(oth_oe),
		.o_interrupt_request_n(irq_n), .i_proto_state(state),
		.i_send_seq(seq), .i_recv_seq(seq), .i_internal_send_request(flag),
		.i_next_ack_expected(seq), .i_prev_next_ack(seq),
		.i_ack_processing_pending(flag), .i_rx_control({2{1'b0, seq}}),
		.i_chain_segment(seq[3:0]), .i_protocol_input(state),
		.i_last_poll_final(flag), .i_reject_bytes({5{1'b0, seq}}),
		.i_modulo_128(m128), .i_id_exchange_enable(xid),
		.i_ext_rdata(8'h5a), .i_irq_valid(irq_v), .i_irq_code(irq_c),
		.i_evt_link_down(evt[0]), .i_evt_tx_not_ready(evt[1]),
		.i_evt_rx_fault(evt[2]), .i_evt_link_reset_rx(evt[3]),
		.i_evt_iframe_lost(evt[4]), .o_link_command(lcmd),
		.o_tx_fill_ones(fill1),
		.o_rx_discard(disc), .o_params_clear(pclr),
		.o_send_disc_frame(sdf),
		.o_enter_station_busy(sbf), .o_pw_verdict(pwv),
		.o_disc_action(da),
		.o_param_wr(pwr), .o_counter_wr(cwr), .o_ext_index(eidx),
		.o_ext_wdata(ewd));

	// outputs are counted at the falling edge, where they are settled
	always @(negedge clk) begin
		if (pwr === 1'b1)
			n_pw++;
		if (cwr === 1'b1)
			n_cw++;
		if (doe === 1'b1)
			n_oe++;
		if (sdf === 1'b1)
			n_sd++;
		if (sbf === 1'b1)
			n_sb++;
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] val);
		host_u.access(1'b1, idx, val, v);
	endtask
	task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
		host_u.access(1'b0, idx, 8'h00, v);
		chk(v, exp);
	endtask
	task automatic pulse(input logic [4:0] e, input logic [5:0] code);
		@(negedge clk);
		evt   = e;
		irq_v = (e == 5'h00);
		irq_c = code;
		@(negedge clk);
		evt   = 5'h00;
		irq_v = 1'b0;
	endtask

	initial begin
		#1000000;
		mismatches++;
		final_report();
	end

	initial begin
		rst_b = 1'b0;
		mr_n  = 1'b1;
		state = 5'h06;
		seq   = 7'h35;
		flag  = 1'b1;
		irq_v = 1'b0;
		irq_c = 6'h00;
		evt   = 5'h00;
		n_pw  = 0;
		n_cw  = 0;
		n_oe  = 0;
		n_sd  = 0;
		n_sb  = 0;
		xid   = 1'b0;
		m128  = 1'b0;
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		repeat (14) @(negedge clk);
		chk({6'h00, fill1, disc}, 8'h03);
		rd_chk(`LCS_IDX_CMD, 8'h82);
		rd_chk(`LCS_IDX_IRQ, 8'h00);
		chk(n_oe[7:0], 8'h08);
		wr(`LCS_IDX_PARAM0, 8'h11);
		chk(n_pw[7:0], 8'h01);
		// keep state select high for passive operation
		wr(`LCS_IDX_CMD, 8'h80);
		chk({6'h00, fill1, disc}, 8'h00);
		wr(`LCS_IDX_PARAM1, 8'h22);
		wr(`LCS_IDX_CNT0, 8'h33);
		chk({n_pw[3:0], n_cw[3:0]}, 8'h11);
		wr(`LCS_IDX_CMD, 8'h82);
		chk({7'h00, fill1}, 8'h01);
		chk({n_sd[3:0], n_sb[3:0]}, 8'h10);
		wr(`LCS_IDX_PARAM0, 8'h44);
		wr(`LCS_IDX_PARAM1, 8'h55);
		chk(n_pw[7:0], 8'h02);
		chk({2'b00, eidx}, 8'h11);
		chk(ewd, 8'h55);
		rd_chk(`LCS_IDX_PARAM1, 8'h5a);
		rd_chk(6'h3f, 8'h00);
		chk({7'h00, hi_oe}, 8'h00);
		rd_chk(`LCS_IDX_STAT0 + 6'h01, 8'hb5);
		rd_chk(`LCS_IDX_STAT0 + 6'h02, 8'h35);
		rd_chk(`LCS_IDX_STAT0 + 6'h03, 8'hb5);
		rd_chk(`LCS_IDX_STAT0 + 6'h05, 8'h35);
		rd_chk(`LCS_IDX_STAT0 + 6'h08, 8'h26);
		rd_chk(`LCS_IDX_STAT0 + 6'h07, 8'h05);
		rd_chk(`LCS_IDX_STAT0 + 6'h06, 8'h00);
		m128 = 1'b1;
		rd_chk(`LCS_IDX_STAT0 + 6'h06, 8'h35);
		rd_chk(`LCS_IDX_STAT0 + 6'h09, 8'h35);
		rd_chk(`LCS_IDX_STAT13, 8'h35);
		m128 = 1'b0;
		for (int i = 1; i <= 5; i++)
			pulse(5'h00, i[5:0]);
		chk({7'h00, irq_n}, 8'h00);
		host_u.access(1'b0, `LCS_IDX_STAT0, 8'h00, v);
		chk(v & 8'h60, 8'h60);
		host_u.access(1'b0, `LCS_IDX_STAT0, 8'h00, v);
		chk(v & 8'h20, 8'h00);
		rd_chk(`LCS_IDX_IRQ, 8'h81);
		for (int i = 2; i <= 4; i++)
			rd_chk(`LCS_IDX_IRQ, i[7:0]);
		rd_chk(`LCS_IDX_IRQ, 8'h00);
		chk({7'h00, irq_n}, 8'h01);
		wr(`LCS_IDX_CMD, 8'h85);
		pulse(5'h01, 6'h00);
		rd_chk(`LCS_IDX_CMD, 8'h84);
		pulse(5'h04, 6'h00);
		rd_chk(`LCS_IDX_CMD, 8'h80);
		chk({n_sd[3:0], n_sb[3:0]}, 8'h11);
		chk({5'h00, da}, {5'h00, lcs_pkg::LCS_DA_REMOTE_INIT});
		wr(`LCS_IDX_CMD, 8'h08);
		chk({5'h00, da}, {5'h00, lcs_pkg::LCS_DA_ACTIVE_SETUP});
		wr(`LCS_IDX_CMD, 8'h00);
		chk({5'h00, da}, {5'h00, lcs_pkg::LCS_DA_DM_FLAG_FILL});
		xid = 1'b1;
		@(negedge clk);
		chk({5'h00, da}, {5'h00, lcs_pkg::LCS_DA_WAIT_ID});
		wr(`LCS_IDX_CMD, 8'h50);
		chk({5'h00, da}, {5'h00, lcs_pkg::LCS_DA_INIT_ID});
		chk({5'h00, pwv}, 8'h05);
		chk(lcmd, 8'h50);
		wr(`LCS_IDX_CMD, 8'h80);
		chk({5'h00, da}, {5'h00, lcs_pkg::LCS_DA_ILLEGAL});
		xid = 1'b0;
		// leaving information transfer raises host done
		state = 5'h04;
		rd_chk(`LCS_IDX_STAT0, 8'hc4);
		wr(`LCS_IDX_STAT0, 8'h00);
		rd_chk(`LCS_IDX_STAT0, 8'h44);
		for (int i = 0; i < 2; i++) begin
			host_u.hold_cs(i[0]);
			@(negedge clk);
			mr_n = 1'b0;
			repeat (6) @(negedge clk);
			chk({5'h00, pclr, iso_oe, oth_oe},
				{5'h00, 1'b1, i[0], 1'b0});
			mr_n = 1'b1;
			host_u.hold_cs(1'b1);
			repeat (14) @(negedge clk);
			rd_chk(`LCS_IDX_CMD, 8'h82);
		end
		final_report();
	end
endmodule
